/* rtl/aser_pkg.sv */
// Constants and carriers for the async serial status block
// Assumes an APB master and per-port receiver/transmitter event logic
package aser_pkg;
    localparam int NPORT = 6;
    localparam int AW = 10;
    // Register indices; byte address is four times the index
    // Port order A, B, C, D, E, F from bit 0 upward
    localparam logic [5:0][7:0] STAT_IDX =
        {8'hdb, 8'hcb, 8'hf3, 8'he3, 8'hd3, 8'hc3};
    localparam logic [7:0] IRQ_EN_IDX = 8'hfe;
    localparam logic [5:0] IRQ_EN_RST = 6'h00;
    localparam logic [1:0] IDX_LSB = 2'h0;
    // Status bit positions
    localparam int B_RXF = 7;
    localparam int B_ADR = 6;
    localparam int B_OVR = 5;
    localparam int B_TXF = 3;
    localparam int B_BSY = 2;

    // Per-port events from receiver, transmitter and data register
    typedef struct packed {
        logic rx_load;       // Byte enters receive data register
        logic rx_ninth;      // Ninth (address) bit of that byte
        logic rx_frame_err;  // Bad stop bit on that byte
        logic rx_start;      // Start bit detected
        logic rx_shift_full; // Receive shift register holds a byte
        logic dr_read;       // Software reads data register
        logic dr_write;      // Software writes data register
        logic tx_take;       // Start bit begins, byte to shifter
        logic tx_stop_end;   // End of stop bit of sent character
    } aser_evt_t;

    typedef struct packed {
        logic rx_full;
        logic adr;
        logic ovr;
        logic tx_full;
        logic busy;
        logic rx_irq;
        logic tx_irq;
    } aser_port_t;

    typedef struct packed {
        aser_port_t [5:0] port;
        logic [5:0] irq_en;
        logic [5:0] irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } aser_st_t;
endpackage

/* rtl/aser_status.sv */
// Status flags and interrupt requests of six async serial ports
// Assumes port events arrive on pclk and an APB master drives the bus
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/10ps
module aser_status (
    input wire logic pclk, // 10 MHz clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [aser_pkg::AW-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire aser_pkg::aser_evt_t [5:0] evt, // Per-port events
    output logic [5:0] irq // Per-port interrupt request
);

    aser_pkg::aser_st_t st_q;
    aser_pkg::aser_st_t st_d;
    logic acc;
    logic fire;
    logic en_hit;
    logic [5:0] stat_hit;
    logic [5:0] stat_wr;

    // Bus phase decode
    assign acc = psel & penable & ~st_q.pready;
    assign fire = psel & penable & st_q.pready;
    assign en_hit = (paddr == {aser_pkg::IRQ_EN_IDX, aser_pkg::IDX_LSB});

    // Per-port status address match
    genvar g;
    generate
        for (g = 0; g < aser_pkg::NPORT; g++)
        begin : g_dec
            assign stat_hit[g] =
                (paddr == {aser_pkg::STAT_IDX[g], aser_pkg::IDX_LSB});
            assign stat_wr[g] = fire & pwrite & stat_hit[g];
        end
    endgenerate

    // Next state of all ports and the bus slave
    always_comb
    begin
        logic rx_set;
        logic tx_set;
        logic [7:0] sbyte;
        logic [31:0] rd;
        rx_set = 1'b0;
        tx_set = 1'b0;
        sbyte = 8'h00;
        rd = 32'h0000_0000;
        st_d = st_q;
        for (int i = 0; i < aser_pkg::NPORT; i++)
        begin
            // Receive buffer full; a refill on the read cycle wins
            if (evt[i].rx_load)
                st_d.port[i].rx_full = 1'b1;
            else if (evt[i].dr_read)
                st_d.port[i].rx_full = 1'b0;
            // Address bit also marks a framing error
            if (evt[i].rx_load)
                st_d.port[i].adr = evt[i].rx_ninth |
                    evt[i].rx_frame_err;
            else if (evt[i].dr_read)
                st_d.port[i].adr = 1'b0;
            // Overrun: start bit while shifter and buffer hold bytes
            if (evt[i].rx_start & evt[i].rx_shift_full &
                st_q.port[i].rx_full)
                st_d.port[i].ovr = 1'b1;
            else if (evt[i].dr_read)
                st_d.port[i].ovr = 1'b0;
            // Receive request on a rise or on a refilling read
            rx_set = evt[i].rx_load &
                (~st_q.port[i].rx_full | evt[i].dr_read);
            if (rx_set)
                st_d.port[i].rx_irq = 1'b1;
            else if (evt[i].dr_read)
                st_d.port[i].rx_irq = 1'b0;
            // Transmit buffer full; a new write wins over the clear
            if (evt[i].dr_write)
                st_d.port[i].tx_full = 1'b1;
            else if (evt[i].tx_take | stat_wr[i])
                st_d.port[i].tx_full = 1'b0;
            // Busy from start bit until end of stop bit
            if (evt[i].tx_take)
                st_d.port[i].busy = 1'b1;
            else if (evt[i].tx_stop_end)
                st_d.port[i].busy = 1'b0;
            // Transmit request on buffer drain or on going idle
            tx_set = st_q.irq_en[i] &
                ((st_q.port[i].tx_full & evt[i].tx_take &
                  ~evt[i].dr_write) |
                 (st_q.port[i].busy & evt[i].tx_stop_end &
                  ~evt[i].tx_take & ~st_q.port[i].tx_full));
            if (tx_set)
                st_d.port[i].tx_irq = 1'b1;
            else if (evt[i].dr_write | stat_wr[i])
                st_d.port[i].tx_irq = 1'b0;
            // One request line per port
            st_d.irq[i] = st_d.port[i].rx_irq |
                st_d.port[i].tx_irq;
        end
        // Read data picked in the first access cycle
        for (int i = 0; i < aser_pkg::NPORT; i++)
        begin
            if (stat_hit[i])
            begin
                sbyte = 8'h00;
                sbyte[aser_pkg::B_RXF] = st_q.port[i].rx_full;
                sbyte[aser_pkg::B_ADR] = st_q.port[i].adr;
                sbyte[aser_pkg::B_OVR] = st_q.port[i].ovr;
                sbyte[aser_pkg::B_TXF] = st_q.port[i].tx_full;
                sbyte[aser_pkg::B_BSY] = st_q.port[i].busy;
                rd = {24'h00_0000, sbyte};
            end
        end
        if (en_hit)
            rd = {26'h000_0000, st_q.irq_en};
        // One wait state, then ready for one cycle
        st_d.pready = acc;
        if (acc)
        begin
            st_d.prdata = pwrite ? 32'h0000_0000 : rd;
            st_d.pslverr = ~en_hit & ~(|stat_hit);
        end
        else
        begin
            st_d.prdata = 32'h0000_0000;
            st_d.pslverr = 1'b0;
        end
        // Interrupt enable register; status writes carry no data
        if (fire & pwrite & en_hit)
            st_d.irq_en = pwdata[5:0];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
            st_q.irq_en <= aser_pkg::IRQ_EN_RST;
        end
        else
            st_q <= st_d;
    end

    // Outputs straight from the state register
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign irq = st_q.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Bus slave timing and reserved status bits
    chk_apb_wait_ready:
        assert property (acc |=> pready && !$past(st_q.pready))
        else $error("ready not one cycle after access");

    chk_apb_ready_pulse:
        assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");

    chk_stat_zero_bits:
        assert property (
            ($past(acc) && !$past(pwrite) && $past(|stat_hit))
            |-> (prdata[4] == 1'b0 && prdata[1:0] == 2'b00))
        else $error("reserved status bits not zero");

    chk_stat_unmapped:
        assert property (
            (acc && !en_hit && !(|stat_hit)) |=> (pready && pslverr))
        else $error("unmapped access not flagged");

    // Bus outputs idle outside the ready cycle, enable register
    chk_apb_setup_wait:
        assert property ((psel && !penable) |=> !pready)
        else $error("ready in the cycle after setup");

    chk_apb_ready_cause:
        assert property (pready |-> $past(acc))
        else $error("ready without an access");

    chk_apb_data_idle:
        assert property (!pready |-> (prdata == 32'h0000_0000))
        else $error("read data outside the ready cycle");

    chk_apb_err_idle:
        assert property (!pready |-> !pslverr)
        else $error("error outside the ready cycle");

    chk_apb_write_data:
        assert property (($past(acc) && $past(pwrite)) |->
            (prdata == 32'h0000_0000))
        else $error("write returned read data");

    chk_en_reg_read:
        assert property (
            ($past(acc) && !$past(pwrite) && $past(en_hit))
            |-> (prdata[31:6] == 26'h000_0000))
        else $error("enable read upper bits not zero");

    chk_en_reg_write:
        assert property ((fire && pwrite && en_hit) |=>
            (st_q.irq_en == $past(pwdata[5:0])))
        else $error("enable write lost");

    chk_en_reg_keep:
        assert property (!(fire && pwrite && en_hit) |=>
            $stable(st_q.irq_en))
        else $error("enable changed without a write");

    // Per-port flag behaviour
    generate
        for (g = 0; g < aser_pkg::NPORT; g++)
        begin : g_chk
            chk_rx_full_set:
                assert property (evt[g].rx_load |=>
                    st_q.port[g].rx_full)
                else $error("receive full not set on load");

            chk_rx_full_clr:
                assert property (
                    (evt[g].dr_read && !evt[g].rx_load) |=>
                    !st_q.port[g].rx_full)
                else $error("receive full not cleared by read");

            chk_rx_irq_rise:
                assert property ($rose(st_q.port[g].rx_full) |->
                    st_q.port[g].rx_irq)
                else $error("receive request missing on rise");

            chk_rx_irq_clr:
                assert property (
                    (evt[g].dr_read && !evt[g].rx_load) |=>
                    !st_q.port[g].rx_irq)
                else $error("receive request not cleared by read");

            chk_rx_irq_again:
                assert property (
                    (evt[g].dr_read && evt[g].rx_load) |=>
                    (st_q.port[g].rx_irq && st_q.port[g].rx_full))
                else $error("refilling read lost the request");

            chk_adr_flag_load:
                assert property (evt[g].rx_load |=>
                    st_q.port[g].adr ==
                    $past(evt[g].rx_ninth | evt[g].rx_frame_err))
                else $error("address flag wrong after load");

            chk_adr_flag_clr:
                assert property (
                    (evt[g].dr_read && !evt[g].rx_load) |=>
                    !st_q.port[g].adr)
                else $error("address flag kept after read");

            chk_ovr_flag_set:
                assert property (
                    (evt[g].rx_start && evt[g].rx_shift_full &&
                     st_q.port[g].rx_full) |=> st_q.port[g].ovr)
                else $error("overrun not flagged");

            chk_ovr_flag_clr:
                assert property (
                    (evt[g].dr_read && !(evt[g].rx_start &&
                     evt[g].rx_shift_full && st_q.port[g].rx_full))
                    |=> !st_q.port[g].ovr)
                else $error("overrun not cleared by read");

            chk_ovr_no_cause:
                assert property (
                    (!st_q.port[g].ovr && !(evt[g].rx_start &&
                     evt[g].rx_shift_full && st_q.port[g].rx_full))
                    |=> !st_q.port[g].ovr)
                else $error("overrun set without cause");

            chk_txf_flag_set:
                assert property (evt[g].dr_write |=>
                    st_q.port[g].tx_full)
                else $error("transmit full not set on write");

            chk_txf_flag_clr:
                assert property (
                    ((evt[g].tx_take || stat_wr[g]) &&
                     !evt[g].dr_write) |=> !st_q.port[g].tx_full)
                else $error("transmit full not cleared");

            chk_tx_irq_fall:
                assert property (
                    (st_q.port[g].tx_full && evt[g].tx_take &&
                     !evt[g].dr_write && st_q.irq_en[g]) |=>
                    (st_q.port[g].tx_irq && irq[g]))
                else $error("transmit request missing on drain");

            chk_tx_irq_masked:
                assert property (
                    (!st_q.irq_en[g] && !st_q.port[g].tx_irq) |=>
                    !st_q.port[g].tx_irq)
                else $error("transmit request while disabled");

            chk_tx_irq_clr:
                assert property (
                    ((evt[g].dr_write || stat_wr[g]) &&
                     !evt[g].tx_take && !evt[g].tx_stop_end) |=>
                    !st_q.port[g].tx_irq)
                else $error("transmit request not cleared");

            chk_busy_flag_set:
                assert property ((evt[g].tx_take && !evt[g].dr_write) |=>
                    (st_q.port[g].busy && !st_q.port[g].tx_full))
                else $error("busy not set at start bit");

            chk_busy_flag_clr:
                assert property (
                    (st_q.port[g].busy && evt[g].tx_stop_end &&
                     !evt[g].tx_take) |=> !st_q.port[g].busy)
                else $error("busy not cleared at stop end");

            chk_busy_idle_irq:
                assert property (
                    (st_q.port[g].busy && evt[g].tx_stop_end &&
                     !evt[g].tx_take && !st_q.port[g].tx_full &&
                     st_q.irq_en[g]) |=> st_q.port[g].tx_irq)
                else $error("idle request missing");

            chk_irq_or_line:
                assert property (irq[g] ==
                    (st_q.port[g].rx_irq | st_q.port[g].tx_irq))
                else $error("port request is not the OR");

            // Flags hold when nothing acts on them
            chk_rx_full_keep:
                assert property (
                    (!evt[g].rx_load && !evt[g].dr_read) |=>
                    $stable(st_q.port[g].rx_full))
                else $error("receive full changed without cause");

            chk_adr_flag_keep:
                assert property (
                    (!evt[g].rx_load && !evt[g].dr_read) |=>
                    $stable(st_q.port[g].adr))
                else $error("address flag changed without cause");

            chk_rx_irq_cause:
                assert property (
                    (!st_q.port[g].rx_irq && !evt[g].rx_load) |=>
                    !st_q.port[g].rx_irq)
                else $error("receive request without a load");

            chk_txf_flag_keep:
                assert property (
                    (!evt[g].dr_write && !evt[g].tx_take && !stat_wr[g])
                    |=> $stable(st_q.port[g].tx_full))
                else $error("transmit full changed without cause");

            chk_busy_flag_keep:
                assert property (
                    (!evt[g].tx_take && !evt[g].tx_stop_end) |=>
                    $stable(st_q.port[g].busy))
                else $error("busy changed without cause");

            chk_tx_irq_cause:
                assert property (
                    (!st_q.port[g].tx_irq && !evt[g].tx_take &&
                     !evt[g].tx_stop_end) |=> !st_q.port[g].tx_irq)
                else $error("transmit request without a cause");
        end
    endgenerate

endmodule

/* tb/aser_remote.sv */
// Remote serial station model driving per-port receiver/transmitter events
// Assumes the bench posts one-cycle requests on pclk
`timescale 1ns/10ps
module aser_remote (
    input wire logic pclk, // Bench clock
    input wire logic presetn, // Async reset, active low
    input wire aser_pkg::aser_evt_t [5:0] req, // Requests from the bench
    output aser_pkg::aser_evt_t [5:0] evt // Events toward the ports
);
    logic [5:0] sf_q;
    logic tog_q;

    // Registers requests; holds shifter level; junk qualifiers off loads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            evt <= '0;
            sf_q <= '0;
            tog_q <= 1'b0;
        end
        else
        begin
            tog_q <= ~tog_q;
            for (int i = 0; i < 6; i++)
            begin
                evt[i] <= req[i];
                if (!req[i].rx_load)
                begin
                    evt[i].rx_ninth <= tog_q;
                    evt[i].rx_frame_err <= ~tog_q;
                end
                if (req[i].rx_shift_full)
                    sf_q[i] <= 1'b1;
                else if (req[i].rx_load)
                    sf_q[i] <= 1'b0;
                evt[i].rx_shift_full <= (sf_q[i] | req[i].rx_shift_full)
                    & ~req[i].rx_load;
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// Bench for the async serial status block with a flag model
// Assumes the remote station model and the APB timing of the block
`timescale 1ns/10ps
module tb_top;
    localparam logic [8:0] E_LD = 9'h100, E_N = 9'h080, E_FE = 9'h040;
    localparam logic [8:0] E_ST = 9'h020, E_SF = 9'h010, E_RD = 9'h008;
    localparam logic [8:0] E_WR = 9'h004, E_TK = 9'h002, E_SE = 9'h001;
    localparam logic [9:0] EA = {aser_pkg::IRQ_EN_IDX, 2'h0};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [5:0] irq;
    aser_pkg::aser_evt_t [5:0] req, dut_evt;
    bit [5:0] rxf, adr, ovr, txf, bsy, rxi, txi, en;
    logic sw, tset, rset;
    bit [31:0] seed = 32'hd43a0fab;
    int miscompares = 0;
    int check_count = 0;

    aser_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .evt(dut_evt), .irq(irq));
    aser_remote u_rem (.pclk(pclk), .presetn(presetn), .req(req),
        .evt(dut_evt));

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Flag model, sampling the same inputs as the block
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {rxf, adr, ovr, txf, bsy, rxi, txi, en} = '0;
        else
        begin
            for (int i = 0; i < 6; i++)
            begin
                sw = psel & penable & pready & pwrite
                    & (paddr == {aser_pkg::STAT_IDX[i], 2'h0});
                tset = en[i] & ((dut_evt[i].tx_take & txf[i]
                    & ~dut_evt[i].dr_write) | (dut_evt[i].tx_stop_end
                    & bsy[i] & ~dut_evt[i].tx_take & ~txf[i]));
                rset = dut_evt[i].rx_load & (~rxf[i] | dut_evt[i].dr_read);
                if (dut_evt[i].dr_write | sw) txi[i] = 0;
                if (tset) txi[i] = 1;
                if (dut_evt[i].dr_read) rxi[i] = 0;
                if (rset) rxi[i] = 1;
                if (dut_evt[i].dr_read) ovr[i] = 0;
                if (dut_evt[i].rx_start & dut_evt[i].rx_shift_full & rxf[i])
                    ovr[i] = 1;
                if (dut_evt[i].dr_read) {rxf[i], adr[i]} = 2'b00;
                if (dut_evt[i].rx_load) {rxf[i], adr[i]} = {1'b1,
                    dut_evt[i].rx_ninth | dut_evt[i].rx_frame_err};
                if (dut_evt[i].tx_take | sw) txf[i] = 0;
                if (dut_evt[i].dr_write) txf[i] = 1;
                if (dut_evt[i].tx_stop_end) bsy[i] = 0;
                if (dut_evt[i].tx_take) bsy[i] = 1;
            end
            if (psel & penable & pready & pwrite & (paddr == EA))
                en = pwdata[5:0];
        end
    end

    function automatic bit [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [9:0] sa(input int p);
        return {aser_pkg::STAT_IDX[p], 2'h0};
    endfunction

    task automatic cmp(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One APB transfer; waits for pready, checks the one wait state
    task automatic apb(input logic w, input logic [9:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        cmp("wait", n, 2);
    endtask

    // Compare request line and status word with the model
    task automatic chk(input int p);
        logic [31:0] r;
        logic e;
        @(negedge pclk);
        cmp("irq", {26'h0, irq}, {26'h0, rxi | txi});
        apb(1'b0, sa(p), 32'h0, r, e);
        cmp("status", r, {24'h0, rxf[p], adr[p], ovr[p], 1'b0, txf[p],
            bsy[p], 2'b00});
    endtask

    // One event pulse toward port p, then a check
    task automatic ev(input int p, input logic [8:0] m);
        @(posedge pclk);
        req[p] <= aser_pkg::aser_evt_t'(m);
        @(posedge pclk);
        req[p] <= '0;
        repeat (2) @(posedge pclk);
        chk(p);
    endtask

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        finish_test();
    end

    // Main sequence
    initial
    begin
        logic [31:0] r, d;
        logic e;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        req = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int p = 0; p < 6; p++) chk(p);
        apb(1'b1, 10'h004, xs(), r, e);
        cmp("write err", {31'h0, e}, 32'h1);
        apb(1'b0, 10'h000, 32'h0, r, e);
        cmp("read err", {31'h0, e}, 32'h1);
        cmp("read data", r, 32'h0);
        for (int p = 0; p < 6; p++)
        begin
            d = xs();
            d[p] = p[0];
            apb(1'b1, EA, d, r, e);
            apb(1'b0, EA, 32'h0, r, e);
            cmp("enable", r, {26'h0, en});
            d = xs();
            ev(p, E_LD | (d[0] ? E_N : 9'h0) | (d[1] ? E_FE : 9'h0));
            ev(p, E_SF);
            ev(p, E_ST);
            ev(p, E_LD | E_RD);
            ev(p, E_RD);
            ev(p, E_WR);
            ev(p, E_TK);
            ev(p, E_WR);
            apb(1'b1, sa(p), xs(), r, e);
            ev(p, 9'h0);
            ev(p, E_SE);
            apb(1'b1, sa(p), xs(), r, e);
            ev(p, 9'h0);
            ev(p, E_WR);
            ev(p, E_TK);
            ev(p, E_WR);
            ev(p, E_SE);
        end
        finish_test();
    end
endmodule
